// ===== core/ssc_pkg.sv
// ****************************************************************
// Register map, list encoding and carrier types
// ****************************************************************
package ssc_pkg;
	localparam logic [11:0] SSC_SEG_LIST_BASE  = 12'hA00;
	localparam int          SSC_SEG_LIST_LEN   = 23;
	localparam logic [11:0] SSC_STATUS_PIN_CTL = 12'h232;
	localparam logic [11:0] SSC_APPLY_CTL      = 12'h234;
	localparam logic [11:0] SSC_XFER_PROGRESS  = 12'hB00;
	localparam logic [11:0] SSC_XFER_ERROR     = 12'hB01;
	localparam logic [11:0] SSC_CONTROL_ONE    = 12'hB02;
	localparam logic [11:0] SSC_CONTROL_TWO    = 12'hB03;
	// Field positions
	localparam int SSC_BUSY_ON_PIN_BIT = 4;
	localparam int SSC_APPLY_BIT       = 0;
	localparam int SSC_WRITE_EN_BIT    = 0;
	localparam int SSC_SOFT_RELOAD_BIT = 1;
	localparam int SSC_STORE_BIT       = 0;
	// Reset values of the control bits
	localparam logic SSC_WRITE_EN_RST    = 1'b0;
	localparam logic SSC_BUSY_ON_PIN_RST = 1'b0;
	// List entries: 0x00-0x7F = count-1 then address high, low bytes
	localparam logic [7:0] SSC_OP_APPLY = 8'h80;
	localparam logic [7:0] SSC_OP_END   = 8'hFF;
	// Default list: six segments cover 0x000-0x2BF, then apply, then end
	localparam logic [7:0] SSC_SEG_LIST_RST [SSC_SEG_LIST_LEN] = '{
		8'h7F, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h80, 8'h7F, 8'h01, 8'h00,
		8'h7F, 8'h01, 8'h80, 8'h7F, 8'h02, 8'h00, 8'h3F, 8'h02, 8'h80,
		8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	// Request toward the buffer register bank
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        we;
	} ssc_bank_req_type;
	typedef enum logic [2:0] {
		SSC_IDLE, SSC_FETCH, SSC_ADDR_HI, SSC_ADDR_LO, SSC_MOVE, SSC_FINISH
	} ssc_state_type;
endpackage : ssc_pkg

// ===== core/ssc_settings_storage.sv
// Contract
// RULE1: Twenty-three byte registers hold segment start addresses and byte counts.
// RULE2: The list also holds apply and end-of-list codes, executed while walking.
// RULE3: Reset fills the list to move every register, then apply.
// RULE4: Progress bit 0 reads 1 while a transfer runs, 0 when done.
// RULE5: With status-pin bit 4 set, busy drives status pin zero.
// RULE6: Error bit 0 reads 1 when transferred data failed its check.
// RULE7: Boot-select low plus control-one bit 1 reloads settings; bit self-clears.
// RULE8: Control-one bit 0 write-enables storage; default 0 blocks writes.
// RULE9: Control-two bit 0 starts a store and clears when it finishes.
// RULE10: Apply copies buffer to active on next serial clock rise; self-clears.
// RULE11: Requests during a transfer are ignored; protected stores leave storage unchanged. Apply requests are still taken mid-transfer.
// RULE12: Host polls busy to zero before new operations, then checks error.
`timescale 1ns/1ps
`default_nettype none
module ssc_settings_storage
	import ssc_pkg::*;
#(
	parameter int STORE_DEPTH = 1024
)(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [11:0]      reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [7:0]            reg_rdata,
	input  wire logic             sclk_pin,
	input  wire logic             boot_sel_pin,
	output ssc_bank_req_type      bank_req,
	input  wire logic [7:0]       bank_rdata,
	output logic                  apply_settings,
	output logic                  soft_reset,
	output logic                  status_pin_zero
);
	localparam int PW = $clog2(STORE_DEPTH);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] sclk_sync;
	logic [2:0] sel_sync;
	logic       sclk_level;
	logic       sclk_rise;
	logic       boot_sel;

	// Three stages; a change counts once the last two agree
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_sync <= 3'h0;
			sel_sync  <= 3'h0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[1:0], sclk_pin};
			sel_sync  <= {sel_sync[1:0], boot_sel_pin};
		end
	end

	// Filtered levels, so a glitch on the pin is not an edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_level <= 1'b0;
			boot_sel   <= 1'b0;
		end
		else
		begin
			if (sclk_sync[1] == sclk_sync[2])
				sclk_level <= sclk_sync[2];
			if (sel_sync[1] == sel_sync[2])
				boot_sel <= sel_sync[2];
		end
	end

	assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_level;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0]    seg_list [SSC_SEG_LIST_LEN];
	logic          write_en;
	logic          busy_on_pin;
	logic          apply_pending;
	logic          store_req;
	logic          data_error;
	logic          storing;
	ssc_state_type state;
	logic          walk_apply;
	logic          walk_done;

	function automatic logic in_list(input logic [11:0] a);
		in_list = (a >= SSC_SEG_LIST_BASE) &&
			(a < SSC_SEG_LIST_BASE + 12'(SSC_SEG_LIST_LEN));
	endfunction : in_list

	wire logic busy      = (state != SSC_IDLE); // RULE4
	wire logic wr_ctl1   = reg_wr && (reg_addr == SSC_CONTROL_ONE);
	wire logic wr_ctl2   = reg_wr && (reg_addr == SSC_CONTROL_TWO);
	// Store only when unprotected and idle; otherwise dropped
	wire logic start_st  = wr_ctl2 && reg_wdata[SSC_STORE_BIT] && write_en && !busy; // RULE8 RULE11
	// Reload only with boot-select low and idle
	wire logic start_ld  = wr_ctl1 && reg_wdata[SSC_SOFT_RELOAD_BIT] && !boot_sel
		&& !busy; // RULE7 RULE11

	// Segment list, reset to the full-map default
	generate
		for (genvar i = 0; i < SSC_SEG_LIST_LEN; i++)
		begin : g_seg
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					seg_list[i] <= SSC_SEG_LIST_RST[i]; // RULE3
				else if (reg_wr && reg_addr == SSC_SEG_LIST_BASE + 12'(i))
					seg_list[i] <= reg_wdata; // RULE1
			end
		end
	endgenerate

	// Plain control bits
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			write_en    <= SSC_WRITE_EN_RST;
			busy_on_pin <= SSC_BUSY_ON_PIN_RST;
		end
		else
		begin
			if (wr_ctl1)
				write_en <= reg_wdata[SSC_WRITE_EN_BIT]; // RULE8
			if (reg_wr && reg_addr == SSC_STATUS_PIN_CTL)
				busy_on_pin <= reg_wdata[SSC_BUSY_ON_PIN_BIT]; // RULE5
		end
	end

	// Store bit stays set for the whole store, then clears itself
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			store_req <= 1'b0;
		else if (start_st)
			store_req <= 1'b1; // RULE9
		else if (walk_done)
			store_req <= 1'b0; // RULE9
	end

	// Apply waits for the next serial clock rise; a new request wins over the clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			apply_pending  <= 1'b0;
			apply_settings <= 1'b0;
		end
		else
		begin
			apply_settings <= apply_pending && sclk_rise; // RULE10
			if ((reg_wr && reg_addr == SSC_APPLY_CTL && reg_wdata[SSC_APPLY_BIT]) || walk_apply)
				apply_pending <= 1'b1; // RULE2 RULE10
			else if (sclk_rise)
				apply_pending <= 1'b0; // RULE10
		end
	end

	// Read data registered on the read strobe
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (in_list(reg_addr))
				reg_rdata <= seg_list[5'(reg_addr - SSC_SEG_LIST_BASE)];
			else if (reg_addr == SSC_STATUS_PIN_CTL)
				reg_rdata <= {3'h0, busy_on_pin, 4'h0};
			else if (reg_addr == SSC_XFER_PROGRESS)
				reg_rdata <= {7'h00, busy}; // RULE4
			else if (reg_addr == SSC_XFER_ERROR)
				reg_rdata <= {7'h00, data_error}; // RULE6
			else if (reg_addr == SSC_CONTROL_ONE)
				reg_rdata <= {7'h00, write_en}; // Reload bit reads 0
			else if (reg_addr == SSC_CONTROL_TWO)
				reg_rdata <= {7'h00, store_req};
			else
				reg_rdata <= 8'h00;
		end
	end

	// Busy is a level taken from the walker state
	assign status_pin_zero = busy_on_pin && busy; // RULE5

	// ****************************************************************
	// List walker and storage
	// ****************************************************************
	logic [7:0]  store_mem [STORE_DEPTH];
	logic [4:0]  list_idx;
	logic [6:0]  remain;
	logic [11:0] seg_addr;
	logic [PW-1:0] ptr;
	logic [7:0]  sum;
	// Reading past the last list byte behaves like an end code, never an unknown
	wire logic [7:0] entry = (list_idx < 5'(SSC_SEG_LIST_LEN)) ? seg_list[list_idx]
		: SSC_OP_END;
	// Running out of list or storage ends the walk like an end code
	wire logic list_end = (entry == SSC_OP_END) ||
		(list_idx == 5'(SSC_SEG_LIST_LEN - 1) && state == SSC_FETCH);

	assign walk_apply = (state == SSC_FETCH) && (entry == SSC_OP_APPLY); // RULE2
	assign walk_done  = (state == SSC_FINISH);

	// One byte moved per cycle; a checksum byte closes each image
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state      <= SSC_IDLE;
			storing    <= 1'b0;
			list_idx   <= 5'h00;
			remain     <= 7'h00;
			seg_addr   <= 12'h000;
			ptr        <= '0;
			sum        <= 8'h00;
			data_error <= 1'b0;
			soft_reset <= 1'b0;
		end
		else
		begin
			soft_reset <= start_ld; // RULE7
			case (state)
				SSC_IDLE:
					if (start_st || start_ld)
					begin
						storing  <= start_st;
						list_idx <= 5'h00;
						ptr      <= '0;
						sum      <= 8'h00;
						state    <= SSC_FETCH;
					end
				SSC_FETCH:
					if (list_end)
						state <= SSC_FINISH; // RULE2
					else if (entry == SSC_OP_APPLY)
						list_idx <= list_idx + 5'h01; // RULE2
					else if (entry[7])
						list_idx <= list_idx + 5'h01; // Unknown codes skipped
					else
					begin
						remain   <= entry[6:0]; // RULE1
						list_idx <= list_idx + 5'h01;
						state    <= SSC_ADDR_HI;
					end
				SSC_ADDR_HI:
				begin
					seg_addr[11:8] <= entry[3:0]; // RULE1
					list_idx       <= list_idx + 5'h01;
					state          <= SSC_ADDR_LO;
				end
				SSC_ADDR_LO:
				begin
					seg_addr[7:0] <= entry; // RULE1
					list_idx      <= list_idx + 5'h01;
					state         <= SSC_MOVE;
				end
				SSC_MOVE:
				begin
					sum      <= sum + (storing ? bank_rdata : store_mem[ptr]);
					seg_addr <= seg_addr + 12'h001;
					ptr      <= ptr + 1'b1; // Checksum lands after the last data byte
					if (ptr == PW'(STORE_DEPTH - 2))
						state <= SSC_FINISH;
					else
					begin
						if (remain == 7'h00)
							state <= SSC_FETCH;
						else
							remain <= remain - 7'h01;
					end
				end
				SSC_FINISH:
				begin
					if (!storing)
						data_error <= (store_mem[ptr] != sum); // RULE6
					else
						data_error <= 1'b0;
					state <= SSC_IDLE;
				end
				default:
					state <= SSC_IDLE;
			endcase
		end
	end

	// Storage written only during an unprotected store
	always_ff @(posedge clk)
	begin
		if (storing && state == SSC_MOVE)
			store_mem[ptr] <= bank_rdata; // RULE8 RULE11
		else if (storing && state == SSC_FINISH)
			store_mem[ptr] <= sum;
	end

	// Bank request: read during store, write during reload
	always_comb
	begin
		bank_req.addr  = seg_addr;
		bank_req.wdata = store_mem[ptr];
		bank_req.we    = !storing && (state == SSC_MOVE);
	end
endmodule : ssc_settings_storage
`default_nettype wire

// ===== testbench/ssc_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Buffer register bank
// ****************************************************************
module ssc_bank_model
	import ssc_pkg::*;
(
	input wire logic             clk,
	input wire ssc_bank_req_type bank_req,
	output logic [7:0]           bank_rdata
);
	logic [7:0] mem [4096];
	// Bytes distinct within each 256-address span so a misplaced byte shows in the sum
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i) ^ 8'h5A;
	end
	// Reload writes land on the edge; plain always since the initial fill also writes mem
	always @(posedge clk)
	begin
		if (bank_req.we)
			mem[bank_req.addr] <= bank_req.wdata;
	end
	assign bank_rdata = mem[bank_req.addr];
endmodule : ssc_bank_model
`default_nettype wire

// ===== testbench/ssc_settings_storage_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module ssc_settings_storage_assertions
	import ssc_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        boot_sel_pin,
	input wire logic        apply_settings,
	input wire logic        soft_reset,
	input wire logic        status_pin_zero
);
	logic pin_en;
	logic wr_en;
	// Shadows of the pin gate and write enable, as written at the port
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_en <= 1'b0;
			wr_en  <= 1'b0;
		end
		else if (reg_wr)
		begin
			if (reg_addr == SSC_STATUS_PIN_CTL)
				pin_en <= reg_wdata[SSC_BUSY_ON_PIN_BIT];
			if (reg_addr == SSC_CONTROL_ONE)
				wr_en <= reg_wdata[SSC_WRITE_EN_BIT];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_pin_gated: assert property (
		status_pin_zero |-> pin_en) else $error("status pin high with gate off");
	a_pin_busy_read: assert property (
		status_pin_zero && reg_rd && reg_addr == SSC_XFER_PROGRESS |=> reg_rdata == 8'h01)
		else $error("busy pin and progress bit disagree");
	a_progress_bits: assert property (
		reg_rd && reg_addr == SSC_XFER_PROGRESS |=> reg_rdata[7:1] == 7'h00)
		else $error("progress reserved bits set");
	a_error_bits: assert property (
		reg_rd && reg_addr == SSC_XFER_ERROR |=> reg_rdata[7:1] == 7'h00)
		else $error("error reserved bits set");
	a_apply_single: assert property (
		apply_settings |=> !apply_settings) else $error("apply pulse too long");
	a_reload_pulse: assert property (
		soft_reset |=> !soft_reset [*8]) else $error("soft reset repeated");
	a_reload_pin_low: assert property (
		soft_reset |-> !boot_sel_pin) else $error("reload with boot select high");
	a_protect_store: assert property (
		!wr_en && reg_rd && reg_addr == SSC_CONTROL_TWO |=> reg_rdata == 8'h00)
		else $error("store started while protected");
endmodule : ssc_settings_storage_assertions
bind ssc_settings_storage ssc_settings_storage_assertions ssc_settings_storage_assertions_inst (
	.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_sel_pin(boot_sel_pin),
	.apply_settings(apply_settings), .soft_reset(soft_reset),
	.status_pin_zero(status_pin_zero));
`default_nettype wire

// ===== testbench/ssc_settings_storage_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_settings_storage_tb import ssc_pkg::*;;
	logic clk, resetn, reg_wr, reg_rd, sclk_pin, boot_sel_pin;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, bank_rdata;
	logic apply_settings, soft_reset, status_pin_zero;
	ssc_bank_req_type bank_req;
	int errors, cmp_count, cycles, applies, resets;
	ssc_settings_storage ssc_settings_storage_inst (.clk(clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sclk_pin(sclk_pin), .boot_sel_pin(boot_sel_pin),
		.bank_req(bank_req), .bank_rdata(bank_rdata), .apply_settings(apply_settings),
		.soft_reset(soft_reset), .status_pin_zero(status_pin_zero));
	ssc_bank_model ssc_bank_model_inst (.clk(clk), .bank_req(bank_req),
		.bank_rdata(bank_rdata));
	// ****************************************************************
	// Clock, pulse counters, hang guard
	// ****************************************************************
	initial clk = 1'b0;
	always #5 clk = ~clk;
	// Falling edge: pulses are settled and the count never races a task's check
	always @(negedge clk)
	begin
		cycles++;
		applies += (apply_settings === 1'b1);
		resets += (soft_reset === 1'b1);
		if (cycles == 20000)
		begin
			errors++;
			close_out();
		end
	end
	task automatic close_out;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	// Strobes last one cycle; a spare edge keeps calls apart
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check(v, exp);
	endtask : chk_rd
	task automatic wait_idle;
		logic [7:0] v = 8'h01;
		int n = 0;
		while (v[0] !== 1'b0 && n < 1000)
		begin
			rd(SSC_XFER_PROGRESS, v);
			n++;
		end
		check(v, 8'h00);
	endtask : wait_idle
	// Serial clock only moves when asked; synchroniser needs several cycles
	task automatic sclk_pulse;
		sclk_pin <= 1'b1;
		repeat (6) @(posedge clk);
		sclk_pin <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : sclk_pulse
	initial
	begin
		{resetn, reg_wr, reg_rd, sclk_pin, boot_sel_pin, reg_addr, reg_wdata} = '0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < SSC_SEG_LIST_LEN; i++)
			chk_rd(SSC_SEG_LIST_BASE + 12'(i), SSC_SEG_LIST_RST[i]);
		chk_rd(SSC_CONTROL_ONE, 8'h00);
		wr(SSC_CONTROL_TWO, 8'h01);
		chk_rd(SSC_CONTROL_TWO, 8'h00);
		wr(SSC_STATUS_PIN_CTL, 8'h10);
		wr(SSC_CONTROL_ONE, 8'h01);
		wr(SSC_CONTROL_TWO, 8'h01);
		check({7'h00, status_pin_zero}, 8'h01);
		chk_rd(SSC_CONTROL_TWO, 8'h01);
		chk_rd(SSC_XFER_PROGRESS, 8'h01);
		wr(SSC_CONTROL_ONE, 8'h03);
		check(8'(resets), 8'h00);
		wait_idle();
		chk_rd(SSC_CONTROL_TWO, 8'h00);
		chk_rd(SSC_XFER_ERROR, 8'h00);
		check({7'h00, status_pin_zero}, 8'h00);
		check(8'(applies), 8'h00);
		sclk_pulse();
		check(8'(applies), 8'h01);
		wr(SSC_APPLY_CTL, 8'h01);
		sclk_pulse();
		check(8'(applies), 8'h02);
		chk_rd(SSC_APPLY_CTL, 8'h00);
		// Reload refused while boot select is high
		boot_sel_pin <= 1'b1;
		repeat (6) @(posedge clk);
		wr(SSC_CONTROL_ONE, 8'h03);
		chk_rd(SSC_XFER_PROGRESS, 8'h00);
		boot_sel_pin <= 1'b0;
		repeat (6) @(posedge clk);
		wr(SSC_CONTROL_ONE, 8'h03);
		check(8'(resets), 8'h01);
		wait_idle();
		chk_rd(SSC_CONTROL_ONE, 8'h01);
		chk_rd(SSC_XFER_ERROR, 8'h00);
		sclk_pulse();
		check(8'(applies), 8'h03);
		// One-byte list no longer matches the stored sum
		wr(SSC_SEG_LIST_BASE + 12'h003, SSC_OP_END);
		wr(SSC_SEG_LIST_BASE, 8'h00);
		chk_rd(SSC_SEG_LIST_BASE + 12'h003, 8'hFF);
		wr(SSC_CONTROL_ONE, 8'h03);
		wait_idle();
		chk_rd(SSC_XFER_ERROR, 8'h01);
		close_out();
	end
endmodule : ssc_settings_storage_tb
`default_nettype wire
